//--- rtl/rxps_pkg.sv
package rxps_pkg;
   // ---------------------------------------------------------------
   // register map, byte addresses on the apb slave
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS     = 8'h00; // control bits
   localparam logic [7:0] MAXLEN_OFS   = 8'h04; // max packet length
   localparam logic [7:0] LEVEL_OFS    = 8'h08; // live level flags
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0c; // sticky events, read only
   localparam logic [7:0] IRQ_EN_OFS   = 8'h10; // event enables
   localparam logic [7:0] IRQ_CLR_OFS  = 8'h14; // write one to clear

   // control fields and reset values
   localparam int          CTRL_PRE_BIT = 0;       // custom preamble enable
   localparam int          CTRL_TPG_BIT = 1;       // test pattern generation
   localparam int          CTRL_LFI_BIT = 2;       // process local fault words
   localparam logic [2:0]  CTRL_RST     = 3'h4;    // fault words processed
   localparam logic [14:0] MAXLEN_RST   = 15'h2580; // plain default length

   // event bits of the interrupt registers
   localparam int         EV_W        = 6;
   localparam int         EV_MISALIGN = 0;
   localparam int         EV_BAD_FCS  = 1;
   localparam int         EV_STOMPED  = 2;
   localparam int         EV_TRUNC    = 3;
   localparam int         EV_BIP      = 4;
   localparam int         EV_ALIGN    = 5;
   localparam logic [5:0] IRQ_EN_RST  = 6'h00;

   // received fault detector timing, in words and receive cycles
   localparam logic [2:0] LF_SET_WORDS = 3'h4;
   localparam logic [7:0] LF_GAP_CYC   = 8'h80;

   // one receive word with its packet side band
   typedef struct packed {
      logic        sop;      // first word of a packet
      logic        valid;    // word carries bytes
      logic        eop;      // last word, fcs fields valid
      logic [4:0]  bytes;    // bytes in this word
      logic [31:0] fcsRx;    // fcs as received
      logic [31:0] fcsCalc;  // fcs as computed
      logic [55:0] preamble; // preamble bytes, valid with sop
   } rxps_pkt_s;

   typedef enum logic {LF_CLEAR, LF_FAULT} rxps_lf_e;
endpackage

//--- rtl/rxps_status.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - alignment loss flag held while error persists
// - misalign pulse at the next metaframe after marker error
// - no misalign before all lanes seen good
// - remote fault flag follows detected condition
// - per physical lane pcs id while synced
// - per pcs lane demux found flag
// - one pulse per bad, unstomped fcs
// - one pulse per stomped, inverted fcs
// - one pulse when length passes maximum
// - internal fault: test pattern, alignment, ber
// - received fault from fault word detector
// - per lane bip8 error pulse
// - high error rate flag held
// - preamble shown when custom preamble enabled
// - preamble valid on first packet cycle
// - local fault is internal or received
module rxps_status #(
   parameter int PCS_LANE_COUNT = 20,
   parameter int ID_W           = 5
) (
   input  wire logic                                   clk,
   input  wire logic                                   sys_rst,
   // apb slave
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [7:0]                             paddr,
   input  wire logic [31:0]                            pwdata,
   output logic      [31:0]                            prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   output logic                                        irq,
   // receive pipeline sources
   input  wire logic                                   alignErr,
   input  wire logic [PCS_LANE_COUNT-1:0]              markerOk,
   input  wire logic [PCS_LANE_COUNT-1:0]              markerWordErr,
   input  wire logic                                   metaframeTick,
   input  wire logic                                   remoteFault,
   input  wire logic [PCS_LANE_COUNT-1:0]              laneSynced,
   input  wire logic [PCS_LANE_COUNT-1:0][ID_W-1:0]    laneIdIn,
   input  wire logic [PCS_LANE_COUNT-1:0]              laneFound,
   input  wire logic [PCS_LANE_COUNT-1:0]              bipErr,
   input  wire logic                                   hiBer,
   input  wire logic                                   lfWord,
   input  wire rxps_pkg::rxps_pkt_s                    pkt,
   // status towards user logic
   output logic                                        alignLostFlag,
   output logic                                        misalignPulse,
   output logic                                        remoteFaultFlag,
   output logic      [PCS_LANE_COUNT-1:0][ID_W-1:0]    physicalLanePcsId,
   output logic      [PCS_LANE_COUNT-1:0]              pcsLaneFoundFlags,
   output logic                                        badFcsPulse,
   output logic                                        stompedFcsPulse,
   output logic                                        truncatedPulse,
   output logic                                        intLocalFault,
   output logic                                        rcvLocalFault,
   output logic                                        localFault,
   output logic      [PCS_LANE_COUNT-1:0]              bipErrPulse,
   output logic                                        errorRateHighFlag,
   output logic      [55:0]                            preambleOut,
   output logic                                        preambleValid
);

   // ---------------------------------------------------------------
   // state declarations
   // ---------------------------------------------------------------
   logic [2:0]                          ctrl, next_ctrl;           // control bits
   logic [14:0]                         maxLen, next_maxLen;       // length limit
   logic [5:0]                          irqEn, next_irqEn;         // event enables
   logic [5:0]                          irqStat, next_irqStat;     // sticky events
   logic [31:0]                         next_prdata;
   logic                                next_pready, next_pslverr, next_irq;
   logic [PCS_LANE_COUNT-1:0]           laneSeen, next_laneSeen;   // good marker seen
   logic                                allSeen, next_allSeen;     // all lanes once
   logic                                badPend, next_badPend;     // waiting for tick
   logic                                next_mis;
   logic                                next_alignLost, next_remote, next_hiBer;
   logic [PCS_LANE_COUNT-1:0][ID_W-1:0] next_id;
   logic [PCS_LANE_COUNT-1:0]           next_found, next_bip;
   logic                                next_bad, next_stomp, next_trunc;
   logic [14:0]                         pktLen, next_pktLen;       // bytes so far
   logic                                truncDone, next_truncDone; // once per packet
   logic [55:0]                         next_preOut;
   logic                                next_preValid;
   rxps_pkg::rxps_lf_e                  lfState, next_lfState;
   logic [2:0]                          lfCnt, next_lfCnt;         // words toward fault
   logic [7:0]                          lfGap, next_lfGap;         // cycles without word
   logic                                next_intLf, next_rcvLf;
   logic                                access, wrEn;
   logic [5:0]                          events;

   // address decode, shared by error response and writes
   function automatic logic isReg(input logic [7:0] a);
      isReg = (a == rxps_pkg::CTRL_OFS) || (a == rxps_pkg::MAXLEN_OFS) ||
              (a == rxps_pkg::LEVEL_OFS) || (a == rxps_pkg::IRQ_STAT_OFS) ||
              (a == rxps_pkg::IRQ_EN_OFS) || (a == rxps_pkg::IRQ_CLR_OFS);
   endfunction

   // ---------------------------------------------------------------
   // level status and per lane flags
   // ---------------------------------------------------------------
   // levels are re-registered so every output leaves a flip-flop
   always_comb begin
      next_alignLost = alignErr;
      next_remote    = remoteFault;
      next_hiBer     = hiBer;
      next_found     = laneFound;
      next_bip       = bipErr;
      for (int i = 0; i < PCS_LANE_COUNT; i++) begin
         // unsynced lanes read zero rather than a stale number
         next_id[i] = laneSynced[i] ? laneIdIn[i] : '0;
      end
      next_intLf = ctrl[rxps_pkg::CTRL_TPG_BIT] | alignErr | hiBer;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alignLostFlag     <= 1'b0;
         remoteFaultFlag   <= 1'b0;
         errorRateHighFlag <= 1'b0;
         pcsLaneFoundFlags <= '0;
         bipErrPulse       <= '0;
         physicalLanePcsId <= '0;
         intLocalFault     <= 1'b0;
      end else begin
         alignLostFlag     <= next_alignLost;
         remoteFaultFlag   <= next_remote;
         errorRateHighFlag <= next_hiBer;
         pcsLaneFoundFlags <= next_found;
         bipErrPulse       <= next_bip;
         physicalLanePcsId <= next_id;
         intLocalFault     <= next_intLf;
      end
   end

   // ---------------------------------------------------------------
   // lane marker misalignment
   // ---------------------------------------------------------------
   // an error is held until the next metaframe boundary, then pulsed
   always_comb begin
      next_laneSeen = laneSeen | markerOk;
      next_allSeen  = allSeen | (&laneSeen);
      next_mis      = badPend & metaframeTick;
      // a new error on the tick waits for the following metaframe
      next_badPend  = (badPend & ~metaframeTick) | (allSeen & (|markerWordErr));
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         laneSeen      <= '0;
         allSeen       <= 1'b0;
         badPend       <= 1'b0;
         misalignPulse <= 1'b0;
      end else begin
         laneSeen      <= next_laneSeen;
         allSeen       <= next_allSeen;
         badPend       <= next_badPend;
         misalignPulse <= next_mis;
      end
   end

   // ---------------------------------------------------------------
   // packet checks: fcs, truncation, preamble
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] sum;
      sum = 16'h0000;
      // stomped is the exact inverse; anything else wrong is bad
      next_stomp = pkt.eop && (pkt.fcsRx == ~pkt.fcsCalc);
      next_bad   = pkt.eop && (pkt.fcsRx != pkt.fcsCalc) && !next_stomp;
      next_pktLen    = pktLen;
      next_truncDone = truncDone;
      next_trunc     = 1'b0;
      if (pkt.valid) begin
         sum = (pkt.sop ? 16'h0000 : {1'b0, pktLen}) + {11'h000, pkt.bytes};
         // count saturates; only the first overrun of a packet pulses
         next_pktLen    = sum[15] ? 15'h7fff : sum[14:0];
         next_trunc     = (pkt.sop || !truncDone) && (sum > {1'b0, maxLen});
         next_truncDone = (pkt.sop ? 1'b0 : truncDone) | next_trunc;
      end
      next_preValid = pkt.sop && pkt.valid && ctrl[rxps_pkg::CTRL_PRE_BIT];
      next_preOut   = next_preValid ? pkt.preamble : preambleOut;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         badFcsPulse     <= 1'b0;
         stompedFcsPulse <= 1'b0;
         truncatedPulse  <= 1'b0;
         pktLen          <= 15'h0000;
         truncDone       <= 1'b0;
         preambleOut     <= 56'h0;
         preambleValid   <= 1'b0;
      end else begin
         badFcsPulse     <= next_bad;
         stompedFcsPulse <= next_stomp;
         truncatedPulse  <= next_trunc;
         pktLen          <= next_pktLen;
         truncDone       <= next_truncDone;
         preambleOut     <= next_preOut;
         preambleValid   <= next_preValid;
      end
   end

   // ---------------------------------------------------------------
   // received local fault detector
   // ---------------------------------------------------------------
   // a run of fault words raises the fault; a long quiet gap drops it
   always_comb begin
      next_lfState = lfState;
      next_lfCnt   = lfCnt;
      next_lfGap   = lfGap;
      if (!ctrl[rxps_pkg::CTRL_LFI_BIT]) begin
         // fault words ignored entirely when processing is off
         next_lfState = rxps_pkg::LF_CLEAR;
         next_lfCnt   = 3'h0;
         next_lfGap   = 8'h00;
      end else if (lfWord) begin
         next_lfGap = 8'h00;
         next_lfCnt = (lfCnt == rxps_pkg::LF_SET_WORDS) ? lfCnt : 3'(lfCnt + 3'h1);
      end else if (lfGap == rxps_pkg::LF_GAP_CYC) begin
         next_lfCnt = 3'h0;
      end else begin
         next_lfGap = 8'(lfGap + 8'h01);
      end
      case (lfState)
         rxps_pkg::LF_CLEAR: begin
            if (next_lfCnt == rxps_pkg::LF_SET_WORDS) begin
               next_lfState = rxps_pkg::LF_FAULT;
            end
         end
         rxps_pkg::LF_FAULT: begin
            if (next_lfCnt == 3'h0) begin
               next_lfState = rxps_pkg::LF_CLEAR;
            end
         end
         default: next_lfState = rxps_pkg::LF_CLEAR;
      endcase
      next_rcvLf = (next_lfState == rxps_pkg::LF_FAULT);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lfState       <= rxps_pkg::LF_CLEAR;
         lfCnt         <= 3'h0;
         lfGap         <= 8'h00;
         rcvLocalFault <= 1'b0;
         localFault    <= 1'b0;
      end else begin
         lfState       <= next_lfState;
         lfCnt         <= next_lfCnt;
         lfGap         <= next_lfGap;
         rcvLocalFault <= next_rcvLf;
         localFault    <= next_intLf | next_rcvLf;
      end
   end

   // ---------------------------------------------------------------
   // apb slave and interrupt registers
   // ---------------------------------------------------------------
   // zero wait states: read data is prepared during the setup cycle
   always_comb begin
      access      = psel & penable & pready;
      wrEn        = access & pwrite & isReg(paddr);
      next_pready = psel & ~penable;
      next_pslverr = psel & ~penable & ~isReg(paddr);
      next_prdata = 32'h0;
      case (paddr)
         rxps_pkg::CTRL_OFS:     next_prdata = {29'h0, ctrl};
         rxps_pkg::MAXLEN_OFS:   next_prdata = {17'h0, maxLen};
         rxps_pkg::LEVEL_OFS:    next_prdata = {25'h0, localFault, rcvLocalFault, intLocalFault,
                                                errorRateHighFlag, remoteFaultFlag, allSeen, alignLostFlag};
         rxps_pkg::IRQ_STAT_OFS: next_prdata = {26'h0, irqStat};
         rxps_pkg::IRQ_EN_OFS:   next_prdata = {26'h0, irqEn};
         default:                next_prdata = 32'h0;
      endcase
      if (!(psel & ~penable)) begin
         next_prdata = prdata;
      end
      next_ctrl   = (wrEn && paddr == rxps_pkg::CTRL_OFS) ? pwdata[2:0] : ctrl;
      next_maxLen = (wrEn && paddr == rxps_pkg::MAXLEN_OFS) ? pwdata[14:0] : maxLen;
      next_irqEn  = (wrEn && paddr == rxps_pkg::IRQ_EN_OFS) ? pwdata[5:0] : irqEn;
      events = '0;
      events[rxps_pkg::EV_MISALIGN] = next_mis;
      events[rxps_pkg::EV_BAD_FCS]  = next_bad;
      events[rxps_pkg::EV_STOMPED]  = next_stomp;
      events[rxps_pkg::EV_TRUNC]    = next_trunc;
      events[rxps_pkg::EV_BIP]      = |next_bip;
      events[rxps_pkg::EV_ALIGN]    = next_alignLost;
      // a new event in the clearing cycle survives the clear
      next_irqStat = (irqStat & ~((wrEn && paddr == rxps_pkg::IRQ_CLR_OFS) ? pwdata[5:0] : 6'h00))
                     | events;
      next_irq = |(next_irqStat & next_irqEn);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl    <= rxps_pkg::CTRL_RST;
         maxLen  <= rxps_pkg::MAXLEN_RST;
         irqEn   <= rxps_pkg::IRQ_EN_RST;
         irqStat <= 6'h00;
         irq     <= 1'b0;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         maxLen  <= next_maxLen;
         irqEn   <= next_irqEn;
         irqStat <= next_irqStat;
         irq     <= next_irq;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_pend_at_tick;
      badPend && metaframeTick;
   endsequence
   sequence s_four_lf;
      (lfWord && ctrl[rxps_pkg::CTRL_LFI_BIT])[*4];
   endsequence

   a_align_lost_follow: assert property (alignErr |=> alignLostFlag ##0 $past(alignErr))
      else $error("alignment loss flag did not follow");
   a_misalign_tick: assert property (s_pend_at_tick |=> misalignPulse)
      else $error("misalign pulse missing at metaframe");
   a_misalign_cause: assert property (misalignPulse |-> $past(metaframeTick) && $past(allSeen))
      else $error("misalign pulse without cause");
   a_fcs_kinds: assert property (pkt.eop && pkt.fcsRx == ~pkt.fcsCalc |=> stompedFcsPulse && !badFcsPulse)
      else $error("stomped fcs not told apart");
   a_fcs_bad: assert property (badFcsPulse |-> $past(pkt.eop) && !stompedFcsPulse)
      else $error("bad fcs pulse without packet end");
   a_id_unsynced: assert property (!laneSynced[0] |=> physicalLanePcsId[0] == '0)
      else $error("lane id shown while unsynced");
   a_int_fault: assert property (hiBer || alignErr |=> intLocalFault && localFault)
      else $error("internal fault not raised");
   a_rcv_fault: assert property (s_four_lf |=> rcvLocalFault)
      else $error("received fault not raised after four words");
   a_preamble_first: assert property (pkt.sop && pkt.valid && ctrl[rxps_pkg::CTRL_PRE_BIT]
      |=> preambleValid && preambleOut == $past(pkt.preamble))
      else $error("preamble not presented on first cycle");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !misalignPulse && !localFault && !irq)
      else $error("outputs active after reset");
endmodule

//--- verification/rxps_link_partner.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: packet words and local fault words off the lanes
// ------------------------------------------------------------
module rxps_link_partner (
   input  wire logic           clk,
   output rxps_pkg::rxps_pkt_s pkt,
   output logic                lfWord
);
   // quiet line at start, nothing flagged
   initial begin
      pkt    = '0;
      lfWord = 1'b0;
   end

   // one packet of 16-byte words; mode 0 good, 1 bad, 2 stomped fcs
   task automatic sendPkt(input int nWords, input logic [1:0] mode, input logic [55:0] pre);
      for (int i = 0; i < nWords; i++) begin
         pkt.sop      <= (i == 0);
         pkt.valid    <= 1'b1;
         pkt.eop      <= (i == nWords - 1);
         pkt.bytes    <= 5'h10;
         pkt.fcsCalc  <= 32'h1234abcd;
         // stomped is the bitwise inverse of the good value
         pkt.fcsRx    <= (mode == 2'h0) ? 32'h1234abcd : (mode == 2'h1) ? 32'h1234abcc : 32'hedcb5432;
         // preamble only means something with sop, so later words carry junk
         pkt.preamble <= (i == 0) ? pre : ~pre;
         @(posedge clk);
      end
      // released word: no qualifiers, inverted preamble and a junk fcs so stale data never matches
      pkt.sop      <= 1'b0;
      pkt.valid    <= 1'b0;
      pkt.eop      <= 1'b0;
      pkt.preamble <= ~pre;
      pkt.fcsRx    <= 32'h0badf00d;
      // idle word stands one edge, so a following packet never reassigns it in the same step
      @(posedge clk);
   endtask

   // local fault words back to back, then the line goes quiet
   task automatic sendLf(input int n);
      repeat (n) begin
         lfWord <= 1'b1;
         @(posedge clk);
      end
      lfWord <= 1'b0;
      @(posedge clk);
   endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin errors++; $display("mismatch %s expected %h seen %h", nm, exp, got); end end
// ------------------------------------------------------------
// bench top: apb access, lane stimulus, pulse tallies
// ------------------------------------------------------------
module tb_top;
   localparam int L = 4; // four lanes keep the vectors readable
   logic                clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, q;
   logic                e, alignErr, metaframeTick, remoteFault, hiBer, lfWord;
   logic [L-1:0]        markerOk, markerWordErr, laneSynced, laneFound, bipErr, pcsLaneFoundFlags, bipErrPulse;
   logic [L-1:0][4:0]   laneIdIn, physicalLanePcsId;
   rxps_pkg::rxps_pkt_s pkt;
   logic                alignLostFlag, misalignPulse, remoteFaultFlag, badFcsPulse, stompedFcsPulse, truncatedPulse;
   logic                intLocalFault, rcvLocalFault, localFault, errorRateHighFlag, preambleValid;
   logic [55:0]         preambleOut, preSeen;
   logic [7:0]          misCnt, badCnt, stCnt, trCnt, preCnt, bipCnt; // pulse tallies, four-state on purpose
   int                  errors, testsRun, cycles;

   rxps_status #(.PCS_LANE_COUNT(L), .ID_W(5)) u_rxps_status (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .alignErr(alignErr),
      .markerOk(markerOk), .markerWordErr(markerWordErr), .metaframeTick(metaframeTick), .remoteFault(remoteFault),
      .laneSynced(laneSynced), .laneIdIn(laneIdIn), .laneFound(laneFound), .bipErr(bipErr), .hiBer(hiBer),
      .lfWord(lfWord), .pkt(pkt), .alignLostFlag(alignLostFlag), .misalignPulse(misalignPulse),
      .remoteFaultFlag(remoteFaultFlag), .physicalLanePcsId(physicalLanePcsId), .pcsLaneFoundFlags(pcsLaneFoundFlags),
      .badFcsPulse(badFcsPulse), .stompedFcsPulse(stompedFcsPulse), .truncatedPulse(truncatedPulse),
      .intLocalFault(intLocalFault), .rcvLocalFault(rcvLocalFault), .localFault(localFault),
      .bipErrPulse(bipErrPulse), .errorRateHighFlag(errorRateHighFlag), .preambleOut(preambleOut),
      .preambleValid(preambleValid));
   rxps_link_partner u_rxps_link_partner (.clk(clk), .pkt(pkt), .lfWord(lfWord));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // tally pulses; a pulse longer than one cycle shows up as an extra count
   always @(posedge clk) begin
      cycles++;
      if (sys_rst) begin
         {misCnt, badCnt, stCnt, trCnt, preCnt, bipCnt} <= '0;
      end else begin
         misCnt <= misCnt + misalignPulse;
         badCnt <= badCnt + badFcsPulse;
         stCnt  <= stCnt + stompedFcsPulse;
         trCnt  <= trCnt + truncatedPulse;
         bipCnt <= bipCnt + bipErrPulse[3];
         preCnt <= preCnt + preambleValid;
         if (preambleValid === 1'b1) preSeen <= preambleOut;
      end
      // a hang is cut short well beyond the few hundred cycles the run needs
      if (cycles == 3000) begin
         errors++;
         endSim();
      end
   end

   // ------------------------------------------------------------
   // apb transfer: setup, access until pready, one idle edge after
   // ------------------------------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rq,
                      output logic re);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never lands in the release time step
      @(posedge clk);
   endtask

   task automatic endSim();
      if (errors == 0 && testsRun > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {alignErr, metaframeTick, remoteFault, hiBer} = 4'h0;
      {markerOk, markerWordErr, laneSynced, laneFound, bipErr, laneIdIn} = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      `CHK("flags after reset", 4'h0, {alignLostFlag, localFault, irq, pready})
      apb(rxps_pkg::CTRL_OFS, 1'b0, 32'h0, q, e);
      `CHK("ctrl reset", 32'h4, q)
      apb(rxps_pkg::MAXLEN_OFS, 1'b0, 32'h0, q, e);
      `CHK("maxlen reset", 32'h2580, q)
      apb(8'h40, 1'b0, 32'h0, q, e);
      `CHK("unmapped read", 33'h100000000, {e, q})
      // level flags follow their causes both ways
      {alignErr, remoteFault, hiBer} <= 3'h7;
      repeat (3) @(posedge clk);
      `CHK("levels on", 5'h1f, {alignLostFlag, remoteFaultFlag, errorRateHighFlag, intLocalFault, localFault})
      {alignErr, remoteFault, hiBer} <= 3'h0;
      repeat (3) @(posedge clk);
      `CHK("levels off", 5'h00, {alignLostFlag, remoteFaultFlag, errorRateHighFlag, intLocalFault, localFault})
      apb(rxps_pkg::CTRL_OFS, 1'b1, 32'h6, q, e);
      repeat (2) @(posedge clk);
      `CHK("test pattern fault", 2'h3, {intLocalFault, localFault})
      apb(rxps_pkg::CTRL_OFS, 1'b1, 32'h4, q, e);
      // lane numbering only where synced, found flags, back to back bip pulses
      laneIdIn   <= {5'h07, 5'h01, 5'h13, 5'h0a};
      laneSynced <= 4'h5;
      laneFound  <= 4'h9;
      bipErr     <= 4'h8;
      repeat (2) @(posedge clk);
      bipErr <= 4'h0;
      repeat (2) @(posedge clk);
      `CHK("lane ids", {5'h00, 5'h01, 5'h00, 5'h0a}, physicalLanePcsId)
      `CHK("found flags", 4'h9, pcsLaneFoundFlags)
      `CHK("bip pulses", 8'h02, bipCnt)
      // marker error before all lanes were seen good must stay silent
      markerWordErr <= 4'h1;
      @(posedge clk);
      markerWordErr <= 4'h0;
      metaframeTick <= 1'b1;
      @(posedge clk);
      metaframeTick <= 1'b0;
      markerOk      <= 4'hf;
      repeat (3) @(posedge clk);
      `CHK("no early misalign", 8'h00, misCnt)
      markerOk      <= 4'h0;
      markerWordErr <= 4'h4;
      @(posedge clk);
      markerWordErr <= 4'h0;
      repeat (2) @(posedge clk);
      metaframeTick <= 1'b1;
      @(posedge clk);
      metaframeTick <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("misalign pulse", 8'h01, misCnt)
      // fcs kinds back to back, irq on bad fcs only
      apb(rxps_pkg::IRQ_EN_OFS, 1'b1, 32'h2, q, e);
      u_rxps_link_partner.sendPkt(3, 2'h0, 56'h0);
      u_rxps_link_partner.sendPkt(2, 2'h1, 56'h0);
      u_rxps_link_partner.sendPkt(2, 2'h2, 56'h0);
      repeat (3) @(posedge clk);
      `CHK("fcs pulses", {8'h01, 8'h01, 8'h00, 8'h00}, {badCnt, stCnt, trCnt, preCnt})
      `CHK("irq raised", 1'b1, irq)
      apb(rxps_pkg::IRQ_STAT_OFS, 1'b0, 32'h0, q, e);
      `CHK("irq status", 2'h3, q[2:1])
      apb(rxps_pkg::IRQ_CLR_OFS, 1'b1, 32'h2, q, e);
      @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      // preamble shown when enabled, truncation past a short maximum
      apb(rxps_pkg::CTRL_OFS, 1'b1, 32'h5, q, e);
      apb(rxps_pkg::MAXLEN_OFS, 1'b1, 32'h28, q, e);
      u_rxps_link_partner.sendPkt(4, 2'h0, 56'h55aa55aa55aa5d);
      repeat (3) @(posedge clk);
      `CHK("preamble", {8'h01, 56'h55aa55aa55aa5d}, {preCnt, preSeen})
      `CHK("truncation", 8'h01, trCnt)
      // received local fault rises after four words, drops after the quiet gap
      u_rxps_link_partner.sendLf(4);
      repeat (2) @(posedge clk);
      `CHK("rcv fault on", 2'h3, {rcvLocalFault, localFault})
      repeat (140) @(posedge clk);
      `CHK("rcv fault off", 2'h0, {rcvLocalFault, localFault})
      endSim();
   end
endmodule
